// *** bench/pg_pullup_model.sv ***
// pull-up on the power good pin, as seen by the host
// assumes the supervisor only ever pulls the pin low
`default_nettype none
module pg_pullup_model (
  input  wire logic power_good_output_o,
  input  wire logic power_good_output_oe_o,
  output logic      power_good_output_i
);
  timeunit 1ns;
  timeprecision 1ps;
  assign power_good_output_i =
    power_good_output_oe_o ? power_good_output_o : 1'b1;
endmodule // pg_pullup_model
`default_nettype wire

// *** bench/testbench.sv ***
// self-checking bench for the output fault supervisor
// assumes the pull-up model on the power good pin
`default_nettype none
module testbench import supervisor_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 0, rst_i = 1, cmd_wr_i = 0, clear_faults_i = 0;
  logic bias_ok_i = 0, control_enable_i = 0, soft_start_done_i = 0;
  logic overvoltage_lowside_select_i = 0, vout_sample_valid_i = 0;
  logic fb_above_ov_fault_i = 0, fb_above_fixed_ov_i = 0;
  logic fb_below_uv_fault_i = 0, fb_above_ov_warn_i = 0;
  logic fb_below_uv_warn_i = 0, fb_prebias_high_i = 0;
  logic fb_below_discharge_i = 0, bandgap_ot_i = 0, pwm_cycle_i = 0;
  logic [7:0] cmd_code_i = 8'h00, window_select_o;
  logic [15:0] cmd_wdata_i = 16'h0000, ton_rise_ms_i = 16'h0001;
  logic [15:0] vout_sample_i = 16'h0000, temp_code_i = 16'h0000;
  logic [15:0] iout_code_i = 16'h0000, cmd_rdata_o;
  logic [1:0] ov_resp_i = 2'h1, uv_resp_i = 2'h0, ot_resp_i = 2'h0;
  logic [1:0] oc_resp_i = 2'h1, ton_max_resp_i = 2'h1;
  logic [STATUS_W-1:0] alert_mask_i = '0;
  logic pwm_enable_o, lowside_force_on_o, soft_start_run_o, smbalert_o;
  logic power_good_output_i, power_good_output_o, power_good_output_oe_o;
  int num_errors = 0, checks = 0;

  output_fault_supervisor #(.MS_CYCLES(10)) dut (.*);
  pg_pullup_model pull (.*);
  // 8 ns system clock
  always #4 clk_sys_i = ~clk_sys_i;

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wr(logic [7:0] c, logic [15:0] d);
    cmd_code_i = c;
    cmd_wdata_i = d;
    cmd_wr_i = 1;
    cyc(1);
    cmd_wr_i = 0;
  endtask
  task automatic rd(logic [7:0] c, logic [15:0] e, string n);
    cmd_code_i = c;
    cyc(1);
    chk(n, e, cmd_rdata_o);
  endtask
  // enable off and on with sticky status cleared
  task automatic recover();
    control_enable_i = 0;
    clear_faults_i = 1;
    cyc(1);
    clear_faults_i = 0;
    control_enable_i = 1;
    cyc(5);
    chk("pwm back", 1, pwm_enable_o);
  endtask
  task automatic t_regs();
    rd(CMD_STARTUP_TIMEOUT, RST_STARTUP_TIMEOUT, "ton reset");
    wr(CMD_OC_FAULT_LIMIT, 16'h0100);
    rd(CMD_OC_FAULT_LIMIT, 16'h0100, "oc limit");
    wr(CMD_WINDOW_LIMITS, 16'h00a5);
    chk("window", 16'h00a5, {8'h00, window_select_o});
    rd(8'h00, 16'h0000, "unmapped");
    $display("test regs done");
  endtask
  // eight ramp samples average to their mean
  task automatic t_vout();
    vout_sample_valid_i = 1;
    for (int i = 1; i <= 8; i++) begin
      vout_sample_i = 16'(i * 256);
      cyc(1);
    end
    vout_sample_valid_i = 0;
    rd(CMD_VOUT_TELEMETRY, 16'h0480, "vout avg");
    $display("test vout done");
  endtask
  task automatic t_up();
    bias_ok_i = 1;
    control_enable_i = 1;
    cyc(3);
    chk("soft start", 1, soft_start_run_o);
    chk("pg start", 0, power_good_output_i);
    soft_start_done_i = 1;
    cyc(5);
    chk("pwm on", 1, pwm_enable_o);
    chk("pg run", 1, power_good_output_i);
    $display("test up done");
  endtask
  task automatic t_ov();
    fb_above_ov_fault_i = 1;
    cyc(1);
    chk("ov pwm", 0, pwm_enable_o);
    chk("ov low", 1, lowside_force_on_o);
    chk("ov alert", 1, smbalert_o);
    chk("ov pg", 0, power_good_output_i);
    fb_above_ov_fault_i = 0;
    cyc(20);
    chk("ov held", 1, lowside_force_on_o);
    chk("ov latch", 0, pwm_enable_o);
    recover();
    chk("alert clr", 0, smbalert_o);
    $display("test ov done");
  endtask
  // three back-to-back overcurrent cycles trip the latch
  task automatic t_oc();
    iout_code_i = 16'h0200;
    pwm_cycle_i = 1;
    repeat (3) begin
      chk("oc pwm", 1, pwm_enable_o);
      cyc(1);
    end
    pwm_cycle_i = 0;
    chk("oc off", 0, pwm_enable_o);
    chk("oc low", 0, lowside_force_on_o);
    iout_code_i = 16'h0000;
    recover();
    $display("test oc done");
  endtask
  task automatic t_ign();
    ov_resp_i = 2'h0;
    fb_above_ov_fault_i = 1;
    cyc(2);
    chk("ign ov pwm", 1, pwm_enable_o);
    fb_below_uv_fault_i = 1;
    cyc(2);
    chk("ign uv pwm", 1, pwm_enable_o);
    fb_above_fixed_ov_i = 1;
    cyc(2);
    chk("fixed ov", 0, pwm_enable_o);
    fb_above_fixed_ov_i = 0;
    fb_above_ov_fault_i = 0;
    fb_below_uv_fault_i = 0;
    recover();
    uv_resp_i = 2'h1;
    fb_below_uv_fault_i = 1;
    cyc(2);
    chk("uv pwm", 0, pwm_enable_o);
    chk("uv low", 0, lowside_force_on_o);
    fb_below_uv_fault_i = 0;
    $display("test ignore done");
  endtask
  // bandgap trip shuts off even with ignore selected
  task automatic t_bg();
    recover();
    bandgap_ot_i = 1;
    cyc(2);
    chk("bg pwm", 0, pwm_enable_o);
    chk("bg low", 0, lowside_force_on_o);
    bandgap_ot_i = 0;
    cyc(3);
    chk("bg retry", 1, pwm_enable_o);
    $display("test bandgap done");
  endtask
  // held below undervoltage until the start-up limit runs out
  task automatic t_ton();
    control_enable_i = 0;
    fb_below_uv_fault_i = 1;
    cyc(1);
    control_enable_i = 1;
    cyc(100);
    chk("ton wait", 1, soft_start_run_o);
    cyc(5);
    chk("ton off", 0, pwm_enable_o);
    fb_below_uv_fault_i = 0;
    $display("test timeout done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence after 4 cycles of reset
  initial begin
    cyc(4);
    rst_i = 0;
    t_regs();
    t_vout();
    t_up();
    t_ov();
    t_oc();
    t_ign();
    t_bg();
    t_ton();
    report_and_stop();
  end
  // watchdog against a hang
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire

// *** design/ms_delay_timer.sv ***
// millisecond delay timer with restart strobe and expiry level
// assumes start strobe and run level come from the supervisor state
`default_nettype none

module ms_delay_timer
  import supervisor_pkg::*;
#(
  parameter int CYC_PER_MS = MS_CYCLES_DEF,
  parameter int TGT_W      = 20
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_i,
  input  wire logic             start_i,
  input  wire logic             run_i,
  input  wire logic [TGT_W-1:0] target_ms_i,
  output logic                  expired_o
);

  localparam int PW = $clog2(CYC_PER_MS + 1);

  typedef struct packed {
    logic [PW-1:0]    presc;
    logic [TGT_W-1:0] ms_cnt;
    logic             expired;
  } tmr_s;

  tmr_s r, n;

  // prescale to milliseconds and compare against target
  always_comb begin
    n = r;
    if (start_i) begin
      n = '0;
    end else if (run_i && !r.expired) begin
      if (r.presc == PW'(CYC_PER_MS - 1)) begin
        n.presc  = '0;
        n.ms_cnt = r.ms_cnt + 1'b1;
      end else begin
        n.presc = r.presc + 1'b1;
      end
      n.expired = (n.ms_cnt >= target_ms_i);
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign expired_o = r.expired;

endmodule : ms_delay_timer

`default_nettype wire

// *** design/output_fault_supervisor.sv ***
// output fault supervisor: limits, fault state machine, power good
// assumes analog comparators and sensor codes synchronous to clk_sys_i
`default_nettype none

module output_fault_supervisor
  import supervisor_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF,
  parameter int SAMPLE_W  = 16,
  parameter int AVG_LOG2  = 3
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  // command port
  input  wire logic                cmd_wr_i,
  input  wire logic [7:0]          cmd_code_i,
  input  wire logic [15:0]         cmd_wdata_i,
  output logic      [15:0]         cmd_rdata_o,
  input  wire logic                clear_faults_i,
  // supply and enable
  input  wire logic                bias_ok_i,
  input  wire logic                control_enable_i,
  input  wire logic                soft_start_done_i,
  input  wire logic [15:0]         ton_rise_ms_i,
  // response settings
  input  wire logic [1:0]          ov_resp_i,
  input  wire logic [1:0]          uv_resp_i,
  input  wire logic [1:0]          ot_resp_i,
  input  wire logic [1:0]          oc_resp_i,
  input  wire logic [1:0]          ton_max_resp_i,
  input  wire logic                overvoltage_lowside_select_i,
  input  wire logic [STATUS_W-1:0] alert_mask_i,
  // sensing
  input  wire logic                vout_sample_valid_i,
  input  wire logic [SAMPLE_W-1:0] vout_sample_i,
  input  wire logic                fb_above_ov_fault_i,
  input  wire logic                fb_above_fixed_ov_i,
  input  wire logic                fb_below_uv_fault_i,
  input  wire logic                fb_above_ov_warn_i,
  input  wire logic                fb_below_uv_warn_i,
  input  wire logic                fb_prebias_high_i,
  input  wire logic                fb_below_discharge_i,
  input  wire logic [15:0]         temp_code_i,
  input  wire logic                bandgap_ot_i,
  input  wire logic                pwm_cycle_i,
  input  wire logic [15:0]         iout_code_i,
  // outputs and power good pin readback
  output logic                     pwm_enable_o,
  output logic                     lowside_force_on_o,
  output logic                     soft_start_run_o,
  output logic [7:0]               window_select_o,
  output logic                     smbalert_o,
  input  wire logic                power_good_output_i,
  output logic                     power_good_output_o,
  output logic                     power_good_output_oe_o
);

  typedef struct packed {
    sup_state_e          state;
    logic [15:0]         oc_limit;
    logic [15:0]         overtemp_fault_limit;
    logic [15:0]         overtemp_warn_limit;
    logic [15:0]         startup_limit;
    logic [7:0]          window;
    logic [STATUS_W-1:0] status;
    logic [15:0]         rdata;
    logic [1:0]          oc_cnt;
    logic                ls_hold;
    logic                wait_bg;
    logic                timer_start;
    logic                pwm_en;
    logic                ls_on;
    logic                ss_run;
    logic                pg_oe;
    logic                alert;
  } sup_s;

  sup_s r, n;

  logic [SAMPLE_W-1:0] vout_avg;
  logic                tmr_expired;
  logic [19:0]         tmr_target;
  logic                ov_now;
  logic                ot_fault_now;
  logic                ot_warn_now;
  logic                ot_cooled;
  logic                oc_over;
  logic                oc_trip;
  logic                tmo_now;
  logic                pg_ok;
  logic [STATUS_W-1:0] sts_set;
  sup_state_e          after_ov;

  vout_averager #(
    .SAMPLE_W (SAMPLE_W),
    .AVG_LOG2 (AVG_LOG2)
  ) u_avg (
    .clk_sys_i      (clk_sys_i),
    .rst_i          (rst_i),
    .sample_valid_i (vout_sample_valid_i),
    .sample_i       (vout_sample_i),
    .average_o      (vout_avg)
  );

  // shared timer: start-up limit or seven rise periods
  always_comb begin
    if (r.state == S_START) begin
      tmr_target = {4'h0, r.startup_limit};
    end else begin
      tmr_target = 20'(HICCUP_RISE_MULT * ton_rise_ms_i);
    end
  end

  ms_delay_timer #(
    .CYC_PER_MS (MS_CYCLES),
    .TGT_W      (20)
  ) u_tmr (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .start_i     (r.timer_start),
    .run_i       (r.state == S_START || r.state == S_HICCUP),
    .target_ms_i (tmr_target),
    .expired_o   (tmr_expired)
  );

  // fault conditions of this cycle
  always_comb begin
    // programmable and fixed overvoltage, gated by bias
    ov_now       = bias_ok_i && (fb_above_ov_fault_i || fb_above_fixed_ov_i);
    ot_fault_now = temp_code_i >= r.overtemp_fault_limit;
    ot_warn_now  = temp_code_i >= r.overtemp_warn_limit;
    ot_cooled    = (r.overtemp_fault_limit > OT_HYST_CODE) &&
                   (temp_code_i < (r.overtemp_fault_limit - OT_HYST_CODE));
    oc_over      = iout_code_i > r.oc_limit;
    oc_trip      = pwm_cycle_i && oc_over &&
                   (r.oc_cnt == OC_TRIP_COUNT - 2'h1);
    // start-up limit reached while still below undervoltage
    tmo_now      = (r.state == S_START) && !r.timer_start &&
                   tmr_expired && fb_below_uv_fault_i;
    if (!control_enable_i) begin
      after_ov = S_OFF;
    end else if (ov_resp_i == RESP_LATCH) begin
      after_ov = S_LATCHED;
    end else begin
      after_ov = S_HICCUP;
    end
  end

  // next state, registers and outputs
  always_comb begin
    n             = r;
    n.timer_start = 1'b0;
    sts_set       = '0;
    pg_ok         = 1'b0;

    // command writes to the limit registers
    if (cmd_wr_i) begin
      if (cmd_code_i == CMD_OC_FAULT_LIMIT) begin
        n.oc_limit = cmd_wdata_i;
      end else if (cmd_code_i == CMD_OVERTEMP_FAULT_LIMIT) begin
        n.overtemp_fault_limit = cmd_wdata_i;
      end else if (cmd_code_i == CMD_OVERTEMP_WARN_LIMIT) begin
        n.overtemp_warn_limit = cmd_wdata_i;
      end else if (cmd_code_i == CMD_STARTUP_TIMEOUT) begin
        n.startup_limit = cmd_wdata_i;
      end else if (cmd_code_i == CMD_WINDOW_LIMITS) begin
        n.window = cmd_wdata_i[7:0];
      end
    end

    // command reads, one cycle latency, unmapped reads zero
    if (cmd_code_i == CMD_OC_FAULT_LIMIT) begin
      n.rdata = r.oc_limit;
    end else if (cmd_code_i == CMD_OVERTEMP_FAULT_LIMIT) begin
      n.rdata = r.overtemp_fault_limit;
    end else if (cmd_code_i == CMD_OVERTEMP_WARN_LIMIT) begin
      n.rdata = r.overtemp_warn_limit;
    end else if (cmd_code_i == CMD_STARTUP_TIMEOUT) begin
      n.rdata = r.startup_limit;
    end else if (cmd_code_i == CMD_WINDOW_LIMITS) begin
      n.rdata = {8'h00, r.window};
    end else if (cmd_code_i == CMD_VOUT_TELEMETRY) begin
      n.rdata = 16'(vout_avg);
    end else if (cmd_code_i == CMD_FAULT_STATUS) begin
      n.rdata = 16'(r.status);
      n.rdata[STS_PG_PIN] = power_good_output_i;
    end else begin
      n.rdata = 16'h0000;
    end

    // consecutive overcurrent counter
    if (pwm_cycle_i) begin
      if (!oc_over) begin
        n.oc_cnt = 2'h0;
      end else if (r.oc_cnt != OC_TRIP_COUNT) begin
        n.oc_cnt = r.oc_cnt + 2'h1;
      end
    end

    // fault state machine
    if (!bias_ok_i) begin
      n.state   = S_OFF;
      n.ls_hold = 1'b0;
    end else begin
      case (r.state)
        S_OFF: begin
          n.ls_hold = 1'b0;
          // prebiased overvoltage acted on before soft-start
          if (ov_now &&
              (fb_above_fixed_ov_i || ov_resp_i != RESP_IGNORE)) begin
            n.state   = S_OV_DISCHARGE;
            n.ls_hold = !overvoltage_lowside_select_i;
          end else if (control_enable_i) begin
            n.state       = S_START;
            n.timer_start = 1'b1;
          end
        end
        S_START, S_RUN: begin
          if (!control_enable_i) begin
            n.state = S_OFF;
          end else if (bandgap_ot_i) begin
            n.state   = S_COOL;
            n.wait_bg = 1'b1;
          end else if (ov_now &&
                       (fb_above_fixed_ov_i || ov_resp_i != RESP_IGNORE)) begin
            n.state   = S_OV_DISCHARGE;
            n.ls_hold = !overvoltage_lowside_select_i;
          end else if (ot_fault_now && ot_resp_i != RESP_IGNORE) begin
            n.state   = (ot_resp_i == RESP_LATCH) ? S_LATCHED : S_COOL;
            n.wait_bg = 1'b0;
          end else if (oc_trip && oc_resp_i != RESP_IGNORE) begin
            n.state       = (oc_resp_i == RESP_LATCH) ? S_LATCHED : S_HICCUP;
            n.timer_start = 1'b1;
          end else if (tmo_now && ton_max_resp_i != RESP_IGNORE) begin
            n.state = (ton_max_resp_i == RESP_LATCH) ? S_LATCHED : S_HICCUP;
            n.timer_start = 1'b1;
          end else if (r.state == S_START) begin
            if (soft_start_done_i && !fb_below_uv_fault_i) begin
              n.state = S_RUN;
            end
          end else if (fb_below_uv_fault_i && uv_resp_i != RESP_IGNORE) begin
            n.state       = (uv_resp_i == RESP_LATCH) ? S_LATCHED : S_HICCUP;
            n.timer_start = 1'b1;
          end
        end
        S_OV_DISCHARGE: begin
          // leave at once when latched on, else at discharge level
          if (!overvoltage_lowside_select_i || fb_below_discharge_i) begin
            n.state       = after_ov;
            n.timer_start = 1'b1;
          end
        end
        S_HICCUP: begin
          if (!control_enable_i) begin
            n.state = S_OFF;
          end else if (!r.timer_start && tmr_expired) begin
            n.state       = S_START;
            n.ls_hold     = 1'b0;
            n.timer_start = 1'b1;
          end
        end
        S_COOL: begin
          // wait for the temperature to fall back
          if (!bandgap_ot_i && (r.wait_bg || ot_cooled)) begin
            n.state       = control_enable_i ? S_START : S_OFF;
            n.timer_start = 1'b1;
          end
        end
        S_LATCHED: begin
          // latch released by an enable off cycle
          if (!control_enable_i) begin
            n.state = S_OFF;
          end
        end
        default: begin
          n.state = S_OFF;
        end
      endcase
    end

    sts_set[STS_OV_FAULT] = ov_now;
    sts_set[STS_UV_FAULT] = (r.state == S_RUN) && fb_below_uv_fault_i;
    sts_set[STS_OV_WARN]  = bias_ok_i &&
                            (fb_above_ov_warn_i || fb_prebias_high_i);
    sts_set[STS_UV_WARN]  = (r.state == S_RUN) && fb_below_uv_warn_i;
    sts_set[STS_OT_FAULT] = ot_fault_now;
    sts_set[STS_OT_WARN]  = ot_warn_now;
    sts_set[STS_OC_FAULT] = oc_trip;
    sts_set[STS_TON_MAX]  = tmo_now;
    sts_set[STS_BG_OT]    = bandgap_ot_i;
    // set wins over a clear in the same cycle
    n.status = (clear_faults_i ? '0 : r.status) | sts_set;
    n.alert  = |(n.status & ~alert_mask_i);

    // FET control follows the next state
    n.pwm_en = (n.state == S_START) || (n.state == S_RUN);
    n.ss_run = (n.state == S_START);
    n.ls_on  = (n.state == S_OV_DISCHARGE) ||
               (n.ls_hold &&
                (n.state == S_HICCUP || n.state == S_LATCHED));

    // power good window and fault pull-down
    pg_ok = (n.state == S_RUN) && (r.state == S_RUN) &&
            !fb_above_ov_warn_i && !fb_below_uv_warn_i &&
            !fb_prebias_high_i && !ov_now && !fb_below_uv_fault_i &&
            !bandgap_ot_i &&
            !(ot_warn_now && ot_resp_i != RESP_IGNORE) &&
            !(ot_fault_now && ot_resp_i != RESP_IGNORE);
    n.pg_oe = !pg_ok;
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      r                <= '0;
      r.state          <= S_OFF;
      r.oc_limit       <= RST_OC_FAULT_LIMIT;
      r.overtemp_fault_limit <= RST_OVERTEMP_FAULT_LIMIT;
      r.overtemp_warn_limit  <= RST_OVERTEMP_WARN_LIMIT;
      r.startup_limit  <= RST_STARTUP_TIMEOUT;
      r.window         <= RST_WINDOW_LIMITS;
      r.pg_oe          <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign cmd_rdata_o            = r.rdata;
  assign pwm_enable_o           = r.pwm_en;
  assign lowside_force_on_o     = r.ls_on;
  assign soft_start_run_o       = r.ss_run;
  assign window_select_o        = r.window;
  assign smbalert_o             = r.alert;
  assign power_good_output_o    = 1'b0;
  assign power_good_output_oe_o = r.pg_oe;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  property p_ov_discharge;
    (r.state == S_RUN) && control_enable_i && !bandgap_ot_i && ov_now &&
    (ov_resp_i != RESP_IGNORE)
    |=> lowside_force_on_o && !pwm_enable_o;
  endproperty
  a_ov_discharge: assert property (p_ov_discharge)
    else $error("overvoltage did not force low-side on");

  property p_ov_flag_alert;
    ov_now && !alert_mask_i[STS_OV_FAULT]
    |=> r.status[STS_OV_FAULT] && smbalert_o;
  endproperty
  a_ov_flag_alert: assert property (p_ov_flag_alert)
    else $error("overvoltage did not flag and alert");

  property p_ov_latch;
    (r.state == S_OV_DISCHARGE) && control_enable_i && bias_ok_i &&
    !overvoltage_lowside_select_i && (ov_resp_i == RESP_LATCH)
    |=> (r.state == S_LATCHED) && lowside_force_on_o;
  endproperty
  a_ov_latch: assert property (p_ov_latch)
    else $error("overvoltage latch-off not taken");

  property p_ov_ignore;
    (r.state == S_RUN) && control_enable_i && bias_ok_i &&
    fb_above_ov_fault_i && !fb_above_fixed_ov_i &&
    (ov_resp_i == RESP_IGNORE) && !bandgap_ot_i && !ot_fault_now &&
    !oc_trip && !fb_below_uv_fault_i
    |=> pwm_enable_o && (r.state == S_RUN);
  endproperty
  a_ov_ignore: assert property (p_ov_ignore)
    else $error("ignored overvoltage stopped switching");

  property p_uv_off;
    (r.state == S_RUN) && control_enable_i && bias_ok_i &&
    fb_below_uv_fault_i && (uv_resp_i != RESP_IGNORE) && !ov_now &&
    !bandgap_ot_i && !ot_fault_now && !oc_trip
    |=> !pwm_enable_o && !lowside_force_on_o;
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("undervoltage did not turn both FETs off");

  property p_startup_timeout;
    tmo_now |=> r.status[STS_TON_MAX];
  endproperty
  a_startup_timeout: assert property (p_startup_timeout)
    else $error("start-up timeout not flagged");

  property p_pg_fault_low;
    ov_now |=> power_good_output_oe_o;
  endproperty
  a_pg_fault_low: assert property (p_pg_fault_low)
    else $error("power good not pulled low on fault");

  property p_bg_shutdown;
    (r.state == S_RUN) && bias_ok_i && control_enable_i && bandgap_ot_i
    |=> !pwm_enable_o && (r.state == S_COOL);
  endproperty
  a_bg_shutdown: assert property (p_bg_shutdown)
    else $error("bandgap overtemperature did not shut off");

  property p_oc_three;
    (pwm_cycle_i && oc_over && bias_ok_i)[*3] |=> r.status[STS_OC_FAULT];
  endproperty
  a_oc_three: assert property (p_oc_three)
    else $error("three overcurrent cycles not flagged");

  property p_latch_hold;
    (r.state == S_LATCHED) && control_enable_i && bias_ok_i
    |=> (r.state == S_LATCHED) && !pwm_enable_o;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch-off released without enable cycle");

endmodule : output_fault_supervisor

`default_nettype wire

// *** design/supervisor_pkg.sv ***
// constants, encodings and state type for the output fault supervisor
// assumes a single 125 MHz system clock and an asynchronous high reset
`default_nettype none

package supervisor_pkg;

  // command codes of the programmable limits, telemetry and status
  localparam logic [7:0] CMD_OC_FAULT_LIMIT  = 8'h46;
  localparam logic [7:0] CMD_OVERTEMP_FAULT_LIMIT  = 8'h4f;
  localparam logic [7:0] CMD_OVERTEMP_WARN_LIMIT   = 8'h51;
  localparam logic [7:0] CMD_STARTUP_TIMEOUT = 8'h62;
  localparam logic [7:0] CMD_WINDOW_LIMITS   = 8'hd7;
  localparam logic [7:0] CMD_VOUT_TELEMETRY  = 8'he0;
  localparam logic [7:0] CMD_FAULT_STATUS    = 8'he1;

  // reset values of the limits
  localparam logic [15:0] RST_OC_FAULT_LIMIT  = 16'hffff;
  localparam logic [15:0] RST_OVERTEMP_FAULT_LIMIT  = 16'hffff;
  localparam logic [15:0] RST_OVERTEMP_WARN_LIMIT   = 16'hffff;
  localparam logic [15:0] RST_STARTUP_TIMEOUT = 16'h000a;
  localparam logic [7:0]  RST_WINDOW_LIMITS   = 8'h00;

  // fault response encodings
  localparam logic [1:0] RESP_IGNORE  = 2'h0;
  localparam logic [1:0] RESP_LATCH   = 2'h1;
  localparam logic [1:0] RESP_RESTART = 2'h2;

  // status bit positions, sticky except the live power good pin bit
  localparam int STS_OV_FAULT  = 0;
  localparam int STS_UV_FAULT  = 1;
  localparam int STS_OV_WARN   = 2;
  localparam int STS_UV_WARN   = 3;
  localparam int STS_OT_FAULT  = 4;
  localparam int STS_OT_WARN   = 5;
  localparam int STS_OC_FAULT  = 6;
  localparam int STS_TON_MAX   = 7;
  localparam int STS_BG_OT     = 8;
  localparam int STATUS_W      = 9;
  localparam int STS_PG_PIN    = 15;

  // timing
  localparam int CLK_PERIOD_NS    = 8;
  localparam int MS_NS            = 1000000;
  localparam int MS_CYCLES_DEF    = MS_NS / CLK_PERIOD_NS;
  localparam int HICCUP_RISE_MULT = 7;
  localparam logic [1:0]  OC_TRIP_COUNT = 2'h3;
  localparam logic [15:0] OT_HYST_CODE  = 16'h0014;

  typedef enum logic [2:0] {
    S_OFF,
    S_START,
    S_RUN,
    S_OV_DISCHARGE,
    S_HICCUP,
    S_COOL,
    S_LATCHED
  } sup_state_e;

endpackage : supervisor_pkg

`default_nettype wire

// *** design/vout_averager.sv ***
// block average of output voltage samples for telemetry
// assumes samples arrive as single-cycle valid strobes
`default_nettype none

module vout_averager
  import supervisor_pkg::*;
#(
  parameter int SAMPLE_W = 16,
  parameter int AVG_LOG2 = 3
) (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_i,
  input  wire logic                sample_valid_i,
  input  wire logic [SAMPLE_W-1:0] sample_i,
  output logic      [SAMPLE_W-1:0] average_o
);

  typedef struct packed {
    logic [SAMPLE_W+AVG_LOG2-1:0] acc;
    logic [AVG_LOG2-1:0]          cnt;
    logic [SAMPLE_W-1:0]          avg;
  } avg_s;

  avg_s r, n;
  logic [SAMPLE_W+AVG_LOG2-1:0] sum;

  always_comb begin
    n   = r;
    sum = r.acc + {{AVG_LOG2{1'b0}}, sample_i};
    if (sample_valid_i) begin
      n.cnt = r.cnt + 1'b1;
      if (&r.cnt) begin
        n.avg = sum[SAMPLE_W+AVG_LOG2-1:AVG_LOG2];
        n.acc = '0;
      end else begin
        n.acc = sum;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign average_o = r.avg;

endmodule : vout_averager

`default_nettype wire
